// ===== logic/io_seq_cfg.svh
// Purpose: Timing constants for the peripheral bus cycle sequencer
// Assumes: 100 MHz system clock
// Notes:   Counts are in system clock cycles
`ifndef IO_SEQ_CFG_SVH
`define IO_SEQ_CFG_SVH
`define IO_SEQ_PHASE_W      2
`define IO_SEQ_SETUP_CNT    2'h1
`define IO_SEQ_ACCESS_CNT   2'h3
`define IO_SEQ_HOLD_CNT     2'h2
`define IO_SEQ_TURN_CNT     4'h8
`define IO_SEQ_PHASE_RST    2'h0
`endif

// ===== logic/io_seq_pkg.sv
// Purpose: Types for the peripheral bus cycle sequencer
// Assumes: Nothing beyond the cfg header
// Notes:   States are one-hot
package io_seq_pkg;
   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_SETUP  = 7'h02,
      ST_STROBE = 7'h04,
      ST_LATCH  = 7'h08,
      ST_HOLD   = 7'h10,
      ST_ACK    = 7'h20,
      ST_DROP   = 7'h40
   } seq_state_t;

   // Request from the main controller
   typedef struct packed {
      logic        is_write;
      logic        is_mem;
      logic [15:0] wdata;
   } cyc_req_t;

   // Active-low bus strobes and enables
   typedef struct packed {
      logic ior_n;
      logic iow_n;
      logic memr_n;
      logic memw_n;
      logic latch_n;
      logic rdoe_n;
      logic wroe_n;
   } bus_ctl_t;
endpackage : io_seq_pkg

// ===== logic/io_bus_cycle_sequencer.sv
// Purpose: Runs I/O and memory-space cycles on the slow peripheral bus
// Assumes: Request, ready and zero-wait inputs sampled on i_clk_sys
// Notes:   One shared 2-bit phase counter times every delay except the write turnaround (turn_ff)
`timescale 1ns/1ns
`include "io_seq_cfg.svh"
module io_bus_cycle_sequencer
   import io_seq_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rstn,
   input  wire logic       i_req,
   input  wire cyc_req_t   i_req_info,
   input  wire logic       i_rdy,
   input  wire logic       i_zws_n,
   input  wire logic [15:0] i_bus_rdata,
   input  wire logic       i_out_ready,
   output logic            o_ack,
   output logic [15:0]     o_rdata,
   output logic            o_out_valid,
   output bus_ctl_t        o_bus_ctl,
   output logic [15:0]     o_bus_wdata,
   output logic [1:0]      o_phase
);
   // Reset release through two flops
   logic rst_a_ff;
   logic rst_b_ff;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_a_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_b_ff <= rst_a_ff;
      end
   end
   wire rstn = rst_b_ff;

   logic [1:0] rdy_sync_ff;
   logic [1:0] zws_sync_ff;
   always_ff @(posedge i_clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdy_sync_ff <= 2'h3;
         zws_sync_ff <= 2'h3;
      end else begin
         rdy_sync_ff <= {rdy_sync_ff[0], i_rdy};
         zws_sync_ff <= {zws_sync_ff[0], i_zws_n};
      end
   end
   wire rdy_s = rdy_sync_ff[1];
   wire zws_s = ~zws_sync_ff[1];

   // Sequencer state
   seq_state_t  state_ff, nxt_state;
   logic [`IO_SEQ_PHASE_W-1:0] phase_ff, nxt_phase;
   logic        clr_phase;
   cyc_req_t    cur_ff, nxt_cur;
   bus_ctl_t    ctl_ff, nxt_ctl;
   logic        ack_ff, nxt_ack;
   logic [3:0]  turn_ff, nxt_turn;   // Cycles since the last bus strobe ended
   logic        cap_valid;
   logic        buf_ready;

   // Strobe selector shared by assert and release
   function automatic bus_ctl_t strobe_on(input bus_ctl_t c, input cyc_req_t r,
                                          input logic on);
      bus_ctl_t o;
      o = c;
      if (r.is_mem && r.is_write) o.memw_n = ~on;
      else if (r.is_mem)          o.memr_n = ~on;
      else if (r.is_write)        o.iow_n  = ~on;
      else                        o.ior_n  = ~on;
      return o;
   endfunction : strobe_on

   // Next-state and phase logic
   always_comb begin
      nxt_state = state_ff;
      nxt_cur   = cur_ff;
      nxt_ctl   = ctl_ff;
      nxt_ack   = 1'b0;
      clr_phase = 1'b0;
      cap_valid = 1'b0;
      nxt_turn  = (turn_ff == `IO_SEQ_TURN_CNT) ? turn_ff : 4'(turn_ff + 4'h1);
      case (state_ff)
         ST_IDLE: begin
            clr_phase = 1'b1;
            if (i_req && buf_ready) begin
               nxt_cur   = i_req_info;
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Write drive only with read enable off
            if (nxt_cur.is_write && turn_ff >= `IO_SEQ_TURN_CNT && ctl_ff.rdoe_n) begin
               nxt_ctl.wroe_n = 1'b0;
            end
            if (!cur_ff.is_write) nxt_ctl.rdoe_n = 1'b0;
            if (phase_ff == `IO_SEQ_SETUP_CNT &&
                (!cur_ff.is_write || !ctl_ff.wroe_n)) begin
               nxt_ctl   = strobe_on(nxt_ctl, cur_ff, 1'b1);
               clr_phase = 1'b1;
               nxt_state = ST_STROBE;
            end else if (phase_ff == `IO_SEQ_SETUP_CNT) begin
               clr_phase = 1'b1;
            end
         end
         ST_STROBE: begin
            if ((phase_ff == `IO_SEQ_ACCESS_CNT && rdy_s) || zws_s) begin
               nxt_ctl.latch_n = 1'b0;  // Harmless pulse on writes
               nxt_state       = ST_LATCH;
            end else if (phase_ff == `IO_SEQ_ACCESS_CNT) begin
               clr_phase = 1'b1;
            end
         end
         ST_LATCH: begin
            // Strobe ends one cycle after latch
            nxt_ctl         = strobe_on(ctl_ff, cur_ff, 1'b0);
            nxt_ctl.latch_n = 1'b1;
            nxt_turn        = 4'h0;
            cap_valid       = !cur_ff.is_write;
            clr_phase       = 1'b1;
            nxt_state       = ST_HOLD;
         end
         ST_HOLD: begin
            if (phase_ff == `IO_SEQ_HOLD_CNT) begin
               nxt_ctl.rdoe_n = 1'b1;
               nxt_ctl.wroe_n = 1'b1;
               nxt_ack        = 1'b1;
               nxt_state      = ST_ACK;
            end
         end
         ST_ACK: begin
            nxt_ack   = 1'b1;
            if (!i_req) begin
               nxt_ack   = 1'b0;
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      // One shared counter for every delay except the turnaround
      nxt_phase = clr_phase ? `IO_SEQ_PHASE_RST : 2'(phase_ff + 2'h1);
   end

   always_ff @(posedge i_clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         phase_ff <= `IO_SEQ_PHASE_RST;
         cur_ff   <= '0;
         ctl_ff   <= '1;
         ack_ff   <= 1'b0;
         turn_ff  <= `IO_SEQ_TURN_CNT;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         cur_ff   <= nxt_cur;
         ctl_ff   <= nxt_ctl;
         ack_ff   <= nxt_ack;
         turn_ff  <= nxt_turn;
      end
   end

   // Two-entry read buffer; no new cycle starts while any word is held
   logic [15:0] buf_mem_ff [2];
   logic [15:0] nxt_mem [2];
   logic        wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [1:0]  cnt_ff, nxt_cnt;
   always_comb begin
      nxt_mem = buf_mem_ff;
      nxt_wp  = wp_ff;
      nxt_rp  = rp_ff;
      nxt_cnt = cnt_ff;
      if (cap_valid) begin
         nxt_mem[wp_ff] = i_bus_rdata;
         nxt_wp         = ~wp_ff;
      end
      if (cnt_ff != 2'h0 && i_out_ready) nxt_rp = ~rp_ff;
      nxt_cnt = 2'(cnt_ff + {1'b0, cap_valid} - {1'b0, (cnt_ff != 2'h0 && i_out_ready)});
   end
   always_ff @(posedge i_clk_sys or negedge rstn) begin
      if (!rstn) begin
         buf_mem_ff[0] <= 16'h0000;
         buf_mem_ff[1] <= 16'h0000;
         wp_ff         <= 1'b0;
         rp_ff         <= 1'b0;
         cnt_ff        <= 2'h0;
      end else begin
         buf_mem_ff <= nxt_mem;
         wp_ff      <= nxt_wp;
         rp_ff      <= nxt_rp;
         cnt_ff     <= nxt_cnt;
      end
   end
   // A held word only blocks new cycles, never one in flight
   assign buf_ready = (cnt_ff == 2'h0);

   // Registered outputs
   always_ff @(posedge i_clk_sys or negedge rstn) begin
      if (!rstn) begin
         o_rdata     <= 16'h0000;
         o_out_valid <= 1'b0;
         o_bus_wdata <= 16'h0000;
      end else begin
         o_rdata     <= nxt_mem[nxt_rp];   // Head word moves with valid, no stale cycle
         o_out_valid <= (nxt_cnt != 2'h0);
         o_bus_wdata <= nxt_cur.wdata;
      end
   end
   assign o_ack     = ack_ff;
   assign o_bus_ctl = ctl_ff;
   assign o_phase   = phase_ff;

   AST_NO_OVERLAP: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      !(!ctl_ff.rdoe_n && !ctl_ff.wroe_n)) else $error("bus enables overlap");
   AST_LATCH_STROBE: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      $fell(ctl_ff.latch_n) && !cur_ff.is_write && !cur_ff.is_mem |=> $rose(ctl_ff.ior_n))
      else $error("read strobe not released one cycle after latch");
   AST_WRAP: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      phase_ff == 2'h3 && !clr_phase |=> phase_ff == 2'h0) else $error("phase wrap");
   AST_START: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      state_ff == ST_IDLE && i_req && buf_ready |=> state_ff == ST_SETUP)
      else $error("idle did not start");
   sequence s_strobe_on;
      $fell(ctl_ff.ior_n) || $fell(ctl_ff.iow_n) || $fell(ctl_ff.memr_n) || $fell(ctl_ff.memw_n);
   endsequence
   AST_SETUP: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      s_strobe_on |-> $past(state_ff) == ST_SETUP) else $error("strobe without setup");
   AST_ACK: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      state_ff == ST_LATCH |-> ##[3:4] ack_ff) else $error("ack late");
   // Back to idle once request drops
   AST_DROP: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      state_ff == ST_ACK && !i_req |=> state_ff == ST_IDLE && !ack_ff)
      else $error("no return to idle");
   AST_ZWS: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      state_ff == ST_STROBE && zws_s |=> !ctl_ff.latch_n ##1 state_ff == ST_HOLD)
      else $error("zero-wait ignored");
   // IO strobes idle in memory cycles
   AST_MEM: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      cur_ff.is_mem |-> ctl_ff.ior_n && ctl_ff.iow_n) else $error("io strobe in mem cycle");
   AST_TURN: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      $fell(ctl_ff.wroe_n) |-> $past(turn_ff) == `IO_SEQ_TURN_CNT)
      else $error("write enable too early");
   // Not ready restarts the access count
   sequence s_access_end_not_ready;
      state_ff == ST_STROBE && phase_ff == `IO_SEQ_ACCESS_CNT && !rdy_s && !zws_s;
   endsequence
   AST_RDY_HOLD: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      s_access_end_not_ready |=> state_ff == ST_STROBE && phase_ff == `IO_SEQ_PHASE_RST)
      else $error("not ready did not stretch strobe");
   AST_CAPTURE: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      state_ff == ST_LATCH && !cur_ff.is_write
      |=> o_out_valid && o_rdata == $past(i_bus_rdata))
      else $error("read word not captured");
   // Write strobe never a single cycle
   sequence s_wr_strobe_fell;
      $fell(ctl_ff.iow_n) || $fell(ctl_ff.memw_n);
   endsequence
   sequence s_wr_strobe_held;
      (!ctl_ff.iow_n || !ctl_ff.memw_n) [*2];
   endsequence
   AST_WR_LEN: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      s_wr_strobe_fell |-> s_wr_strobe_held) else $error("write strobe too short");
   // Idle keeps every strobe and ack off
   AST_IDLE_QUIET: assert property (@(posedge i_clk_sys) disable iff (!rstn)
      state_ff == ST_IDLE |-> ctl_ff == 7'h7F && !ack_ff) else $error("idle not quiet");
endmodule : io_bus_cycle_sequencer

// ===== tb/periph_model.sv
// Purpose: Slow peripheral model on the far side of the bus
// Assumes: Strobes active low; rdy and zws_n have pull-ups
// Notes:   Released data lines show the inverse of the last word
`timescale 1ns/1ns
module periph_model
   import io_seq_pkg::*;
(
   input  wire bus_ctl_t    i_ctl,
   input  wire logic        i_clk_sys,
   input  wire logic [3:0]  i_wait,
   input  wire logic        i_zws_on,
   input  wire logic [15:0] i_data,
   output logic             o_rdy,
   output logic             o_zws_n,
   output logic [15:0]      o_rdata
);
   logic [3:0]  cnt_ff  = 4'h0;
   logic [15:0] last_ff = 16'h0;
   logic        rd_on;
   logic        st_on;
   assign rd_on = !i_ctl.ior_n || !i_ctl.memr_n;
   assign st_on = rd_on || !i_ctl.iow_n || !i_ctl.memw_n;
   always @(posedge i_clk_sys) cnt_ff <= st_on ? cnt_ff + 4'(cnt_ff < i_wait) : 4'h0;
   assign o_rdy = !(st_on && cnt_ff < i_wait);
   assign o_zws_n = !(st_on && i_zws_on);
   // Floating bus must not look like a held word
   always @(posedge i_clk_sys) if (rd_on) last_ff <= i_data;
   assign o_rdata = rd_on ? i_data : ~last_ff;
endmodule : periph_model

// ===== tb/io_bus_cycle_sequencer_tb.sv
// Purpose: Self-checking bench for the peripheral bus cycle sequencer
// Assumes: Model answers strobes; bench drives requests and buffer ready
// Notes:   Stretch and zero-wait lengths compare with a plain read
`timescale 1ns/1ns
module io_bus_cycle_sequencer_tb
   import io_seq_pkg::*;
();
   logic        i_clk_sys = 1'b0;
   logic        i_rstn    = 1'b0;
   logic        i_req     = 1'b0;
   logic        i_out_ready = 1'b0;
   logic        zon       = 1'b0;
   logic [3:0]  wt        = 4'h0;
   logic [15:0] pdata     = 16'h0000;
   cyc_req_t    i_req_info = '0;
   logic        i_rdy, i_zws_n, o_ack, o_out_valid, prv_rd, prv_lat, prv_wroe;
   logic [15:0] i_bus_rdata, o_rdata, o_bus_wdata;
   logic [1:0]  o_phase, prv_ph;
   logic [3:0]  stb, seen;
   bus_ctl_t    o_bus_ctl;
   int          errors = 0, checks = 0, slen, since = 9, rdend = 99, oeend = 99, nom;
   assign stb = ~{o_bus_ctl.ior_n, o_bus_ctl.iow_n, o_bus_ctl.memr_n, o_bus_ctl.memw_n};
   always #5 i_clk_sys = ~i_clk_sys;
   io_bus_cycle_sequencer dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(i_req),
      .i_req_info(i_req_info), .i_rdy(i_rdy), .i_zws_n(i_zws_n), .i_bus_rdata(i_bus_rdata),
      .i_out_ready(i_out_ready), .o_ack(o_ack), .o_rdata(o_rdata), .o_out_valid(o_out_valid),
      .o_bus_ctl(o_bus_ctl), .o_bus_wdata(o_bus_wdata), .o_phase(o_phase));
   periph_model periph_u (.i_ctl(o_bus_ctl), .i_clk_sys(i_clk_sys), .i_wait(wt),
      .i_zws_on(zon), .i_data(pdata), .o_rdy(i_rdy), .o_zws_n(i_zws_n),
      .o_rdata(i_bus_rdata));
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic end_sim();
      $display("Checks %0d, errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // Wire watcher, sampled mid-cycle where outputs are settled
   always @(negedge i_clk_sys) if (i_rstn) begin
      slen  = slen + int'(|stb);
      seen  = seen | stb;
      since = (|stb) ? 0 : since + 1;
      rdend = (stb[3] | stb[1]) ? 0 : rdend + 1;
      oeend = !o_bus_ctl.rdoe_n ? 0 : oeend + 1;
      chk(!(!o_bus_ctl.rdoe_n && !o_bus_ctl.wroe_n), "enables overlap");
      if (prv_wroe && !o_bus_ctl.wroe_n)
         chk(rdend >= 8 && oeend >= 3, "write enable too early");
      if (!zon && prv_rd && !(stb[3] | stb[1]))
         chk(prv_lat, "read strobe end not after latch");
      chk(o_phase === prv_ph || o_phase === 2'(prv_ph + 2'h1) || o_phase === 2'h0,
          "phase jump");
      prv_rd   = stb[3] | stb[1];
      prv_lat  = !o_bus_ctl.latch_n;
      prv_wroe = o_bus_ctl.wroe_n;
      prv_ph   = o_phase;
   end
   // One whole cycle: request, wait ack, judge, drop request
   task automatic run_cyc(input logic w, input logic m, input logic [15:0] d,
                          input logic b2b);
      int n;
      @(posedge i_clk_sys);
      i_req_info <= '{is_write: w, is_mem: m, wdata: d};
      i_req <= 1'b1;
      slen = 0;
      seen = 4'h0;
      n = 0;
      while (o_ack !== 1'b1 && n < 80) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      chk(n < 80, "no acknowledge");
      if (n >= 80) end_sim();
      chk(since >= 2, "ack before address hold");
      chk(seen === (4'h8 >> {m, w}), "wrong strobe used");
      if (w) chk(o_bus_wdata === d && slen >= 2, "write data or length");
      else chk(o_out_valid === 1'b1 && o_rdata === pdata, "read word");
      @(posedge i_clk_sys);
      i_req <= 1'b0;
      i_out_ready <= b2b;
      // Back to back: drain the word in one cycle while request is low for two cycles
      if (b2b) begin
         @(posedge i_clk_sys);
         i_out_ready <= 1'b0;
         #1 chk(o_ack === 1'b0 && o_out_valid === 1'b0, "ack or word kept");
      end else begin
         repeat (3) @(posedge i_clk_sys);
         chk(o_ack === 1'b0, "ack kept after request drop");
      end
   endtask : run_cyc
   task automatic pop();
      @(posedge i_clk_sys);
      i_out_ready <= 1'b1;
      @(posedge i_clk_sys);
      i_out_ready <= 1'b0;
      #1 chk(o_out_valid === 1'b0, "buffer not drained");
   endtask : pop
   task automatic t_reset();
      #1 chk(o_bus_ctl === 7'h7F && o_ack === 1'b0 && o_phase === 2'h0
         && o_out_valid === 1'b0, "reset state");
      $display("test reset done");
   endtask : t_reset
   // Read then write with near back-to-back timing, both spaces
   task automatic t_rw();
      for (int m = 0; m < 2; m++) begin
         pdata = 16'hA55A ^ 16'(m);
         run_cyc(1'b0, 1'(m), 16'h0000, 1'b1);
         nom = slen;
         run_cyc(1'b1, 1'(m), 16'h3C0F, 1'b0);
      end
      $display("test read write done");
   endtask : t_rw
   task automatic t_rdy();
      wt = 4'h4;
      pdata = 16'h1234;
      run_cyc(1'b0, 1'b0, 16'h0000, 1'b0);
      chk(slen > nom, "rdy did not stretch");
      pop();
      wt = 4'h0;
      $display("test rdy done");
   endtask : t_rdy
   task automatic t_zws();
      zon = 1'b1;
      pdata = 16'h00FF;
      run_cyc(1'b0, 1'b1, 16'h0000, 1'b0);
      chk(slen < nom, "zero-wait did not shorten");
      pop();
      zon = 1'b0;
      $display("test zero-wait done");
   endtask : t_zws
   // Held word blocks the next request until drained
   task automatic t_buf();
      pdata = 16'hBEEF;
      run_cyc(1'b0, 1'b0, 16'h0000, 1'b0);
      pdata = 16'hC001;
      @(posedge i_clk_sys);
      i_req <= 1'b1;
      repeat (30) @(posedge i_clk_sys);
      #1 chk(o_ack === 1'b0 && o_rdata === 16'hBEEF, "request not held off");
      pop();
      run_cyc(1'b0, 1'b0, 16'h0000, 1'b0);
      pop();
      $display("test buffer done");
   endtask : t_buf
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      t_reset();
      t_rw();
      t_rdy();
      t_zws();
      t_buf();
      end_sim();
   end
endmodule : io_bus_cycle_sequencer_tb
